// ==== logic/flash_self_program_access_regs.svh ====
// register offsets, field positions, reset values and region constants
`ifndef FLASH_SELF_PROGRAM_ACCESS_REGS_SVH
`define FLASH_SELF_PROGRAM_ACCESS_REGS_SVH

`define FSPA_ADDR_W 12
`define FSPA_PTR_W 13
`define FSPA_OFF_CTRL 12'h000
`define FSPA_OFF_STATUS 12'h004
`define FSPA_OFF_LOCK 12'h008
`define FSPA_OFF_IRQ_STAT 12'h00c
`define FSPA_OFF_IRQ_MASK 12'h010
`define FSPA_OFF_LAST_PTR 12'h014
`define FSPA_CTRL_READ_EN 0
`define FSPA_ST_BUSY 0
`define FSPA_ST_ACTIVE 1
`define FSPA_ST_HALT 2
`define FSPA_ST_FUSE_LO 4
`define FSPA_IRQ_DONE 0
`define FSPA_IRQ_REFUSED 1
`define FSPA_IRQ_W 2
`define FSPA_LOCK_RESET 4'hf
`define FSPA_LOCK_APP_LO 0
`define FSPA_LOCK_BOOT_LO 2
`define FSPA_HALT_REGION_START 12'hc00
`define FSPA_BOOT_START_SZ0 12'hc00
`define FSPA_BOOT_START_SZ1 12'he00
`define FSPA_BOOT_START_SZ2 12'hf00
`define FSPA_BOOT_START_SZ3 12'hf80

`endif

// ==== logic/flash_self_program_access_pkg.sv ====
// types shared by the self-programming access block
package flash_self_program_access_pkg;

    typedef enum logic [1:0] {
        OP_LOAD = 2'h0,
        OP_ERASE = 2'h1,
        OP_WRITE = 2'h2,
        OP_NONE = 2'h3
    } prog_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } seq_state_t;

endpackage

// ==== logic/flash_self_program_access.sv ====
// flash self-programming access control with apb registers
// Functional notes
// - flash splits into application and boot-loader regions, boundary from boot size fuses
// - application and boot-loader lock bit sets are kept and set independently
// - store-program fetched from application region is refused
// - store-program starts programming only when fetched from boot-loader region
// - boot-loader store-program may erase or write any page whose region lock bit 0 is unprogrammed, boot-loader too
// - fixed concurrent-read and halting regions, independent of fuses
// - programming concurrent-read page keeps processor running
// - programming halting-region page stalls processor for whole operation
// - region choice comes from program address pointer, not fetch address
// - boot-loader region always lies inside halting region
// - busy flag reads one while concurrent-read region is blocked
// - busy flag set when erase or write of concurrent-read page starts
// - busy flag cleared by read enable after completion, or by page load
// - lock bits only programmed (cleared) by software, restored to ones only by chip erase or reset
`timescale 1ns/1ps
`include "flash_self_program_access_regs.svh"

module flash_self_program_access (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [1:0] BOOT_SIZE_FUSES_I,
    input wire logic CHIP_ERASE_I,
    input wire logic PROG_REQ_I,
    input wire flash_self_program_access_pkg::prog_op_t PROG_OP_I,
    input wire logic [11:0] PROG_PC_I,
    input wire logic [12:0] PROG_PTR_I,
    output logic PROG_DONE_O,
    output logic PROG_REFUSED_O,
    output logic FLASH_START_O,
    output flash_self_program_access_pkg::prog_op_t FLASH_OP_O,
    output logic [12:0] FLASH_PTR_O,
    input wire logic FLASH_DONE_I,
    output logic CPU_HALT_O,
    output logic CONC_BUSY_O,
    output logic IRQ_O
);
    import flash_self_program_access_pkg::*;

    // boot-loader start word address per fuse code
    function automatic logic [11:0] boot_start(input logic [1:0] sz);
        case (sz)
            2'h0: boot_start = `FSPA_BOOT_START_SZ0;
            2'h1: boot_start = `FSPA_BOOT_START_SZ1;
            2'h2: boot_start = `FSPA_BOOT_START_SZ2;
            default: boot_start = `FSPA_BOOT_START_SZ3;
        endcase
    endfunction

    // true when a word address lies in the halting region
    function automatic logic in_halt(input logic [11:0] wa);
        in_halt = (wa >= `FSPA_HALT_REGION_START);
    endfunction

    // pin synchronisers
    logic [1:0] fuse_s1;
    logic [1:0] fuse_s2;
    logic erase_s1;
    logic erase_s2;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fuse_s1 <= 2'h0;
            fuse_s2 <= 2'h0;
        end else begin
            fuse_s1 <= BOOT_SIZE_FUSES_I;
            fuse_s2 <= fuse_s1;
        end
    end

    // chip erase pin, same two-flop treatment
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            erase_s1 <= 1'b0;
            erase_s2 <= 1'b0;
        end else begin
            erase_s1 <= CHIP_ERASE_I;
            erase_s2 <= erase_s1;
        end
    end

    // state
    seq_state_t state;
    seq_state_t next_state;
    logic busy;
    logic halt;
    logic [3:0] lock;
    logic [`FSPA_IRQ_W-1:0] irq_stat;
    logic [`FSPA_IRQ_W-1:0] irq_mask;
    logic [12:0] last_ptr;
    prog_op_t run_op;

    // region decode
    wire [11:0] boot_base = boot_start(fuse_s2);
    wire pc_in_boot = (PROG_PC_I >= boot_base);
    // the target region comes from the pointer, never from the fetch address
    wire [11:0] tgt_word = PROG_PTR_I[12:1];
    wire tgt_in_boot = (tgt_word >= boot_base);
    wire tgt_halt = in_halt(tgt_word);
    wire [1:0] app_lock = lock[`FSPA_LOCK_APP_LO +: 2];
    wire [1:0] boot_lock = lock[`FSPA_LOCK_BOOT_LO +: 2];
    // lock bit 0 programmed forbids store-program writes into that region
    wire tgt_locked = tgt_in_boot ? ~boot_lock[0] : ~app_lock[0];
    wire is_prog = (PROG_OP_I == OP_ERASE) || (PROG_OP_I == OP_WRITE);
    wire is_load = (PROG_OP_I == OP_LOAD);
    wire idle = (state == ST_IDLE);
    wire run = (state == ST_RUN);

    // request decision; any request during a run is refused
    wire req_ok = PROG_REQ_I && idle && pc_in_boot;
    wire start_prog = req_ok && is_prog && !tgt_locked;
    wire do_load = req_ok && is_load;
    wire refuse = PROG_REQ_I && !(start_prog || do_load);
    // the flash macro runs on this clock, so its done needs no synchroniser
    wire finish = run && FLASH_DONE_I;

    // true when the bus address selects the register at byte offset off
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
        reg_hit = (a == off);
    endfunction

    // apb decode
    wire apb_acc = PSEL_I && PENABLE_I;
    wire apb_wr = apb_acc && PWRITE_I;
    wire hit_ctrl = reg_hit(PADDR_I, `FSPA_OFF_CTRL);
    wire hit_status = reg_hit(PADDR_I, `FSPA_OFF_STATUS);
    wire hit_lock = reg_hit(PADDR_I, `FSPA_OFF_LOCK);
    wire hit_istat = reg_hit(PADDR_I, `FSPA_OFF_IRQ_STAT);
    wire hit_imask = reg_hit(PADDR_I, `FSPA_OFF_IRQ_MASK);
    wire hit_last = reg_hit(PADDR_I, `FSPA_OFF_LAST_PTR);
    wire hit_any = hit_ctrl | hit_status | hit_lock | hit_istat | hit_imask | hit_last;
    wire wr_read_en = apb_wr && hit_ctrl && PWDATA_I[`FSPA_CTRL_READ_EN];

    // status word, unused bits read zero
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0;
        status_word[`FSPA_ST_BUSY] = busy;
        status_word[`FSPA_ST_ACTIVE] = run;
        status_word[`FSPA_ST_HALT] = halt;
        status_word[`FSPA_ST_FUSE_LO +: 2] = fuse_s2;
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_status) begin
            rd_mux = status_word;
        end else if (hit_lock) begin
            rd_mux = {28'h0, lock};
        end else if (hit_istat) begin
            rd_mux = {30'h0, irq_stat};
        end else if (hit_imask) begin
            rd_mux = {30'h0, irq_mask};
        end else if (hit_last) begin
            rd_mux = {19'h0, last_ptr};
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start_prog) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (FLASH_DONE_I) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // processor stall only for halting-region targets; start and finish never meet
    wire next_halt = start_prog ? tgt_halt : (finish ? 1'b0 : halt);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            halt <= 1'b0;
        end else begin
            halt <= next_halt;
        end
    end

    // concurrent-region busy flag; a start wins over a clear
    wire busy_set = start_prog && !tgt_halt;
    // a read-enable write during a run is ignored, so the region stays blocked
    wire busy_clr = do_load || (wr_read_en && idle);
    wire next_busy = busy_set || (busy && !busy_clr);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            busy <= 1'b0;
        end else begin
            busy <= next_busy;
        end
    end

    // lock bits: writes only program (clear) bits, chip erase restores them all
    // bit 1 of each set is kept for software but gates nothing here
    wire lock_wr = apb_wr && hit_lock;
    wire [3:0] lock_after_wr = lock_wr ? (lock & PWDATA_I[3:0]) : lock;
    wire [3:0] next_lock = erase_s2 ? `FSPA_LOCK_RESET : lock_after_wr;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            lock <= `FSPA_LOCK_RESET;
        end else begin
            lock <= next_lock;
        end
    end

    // interrupt status, write one to clear, a new event wins over its clear
    wire [`FSPA_IRQ_W-1:0] irq_set = {refuse, finish | do_load};
    wire irq_stat_wr = apb_wr && hit_istat;
    wire [`FSPA_IRQ_W-1:0] irq_clr = irq_stat_wr ? PWDATA_I[`FSPA_IRQ_W-1:0] : 2'h0;
    wire [`FSPA_IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_stat <= 2'h0;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    // interrupt mask, same layout as the status
    wire irq_mask_wr = apb_wr && hit_imask;
    wire [`FSPA_IRQ_W-1:0] next_irq_mask = irq_mask_wr ? PWDATA_I[`FSPA_IRQ_W-1:0] : irq_mask;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_mask <= 2'h0;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // flash macro command: one start pulse per accepted erase or write
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            FLASH_START_O <= 1'b0;
        end else begin
            FLASH_START_O <= start_prog;
        end
    end

    // op of the last started operation, held for the flash macro
    prog_op_t next_run_op;
    assign next_run_op = start_prog ? PROG_OP_I : run_op;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            run_op <= OP_NONE;
        end else begin
            run_op <= next_run_op;
        end
    end

    // pointer of the last started operation, also readable over the bus
    wire [12:0] next_last_ptr = start_prog ? PROG_PTR_I : last_ptr;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            last_ptr <= 13'h0;
        end else begin
            last_ptr <= next_last_ptr;
        end
    end

    // done pulse one cycle after a load or after the flash macro finishes
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PROG_DONE_O <= 1'b0;
        end else begin
            PROG_DONE_O <= finish | do_load;
        end
    end

    // refusal pulse one cycle after the request
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PROG_REFUSED_O <= 1'b0;
        end else begin
            PROG_REFUSED_O <= refuse;
        end
    end

    // read data is loaded at the setup edge so that it stands through the access phase
    wire [31:0] next_prdata = (PSEL_I && !PWRITE_I) ? rd_mux : 32'h0;
    // an unmapped address is flagged at setup and answered with an error in access
    wire next_pslverr = PSEL_I && !PENABLE_I && !hit_any;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PRDATA_O <= 32'h0;
        end else begin
            PRDATA_O <= next_prdata;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PSLVERR_O <= 1'b0;
        end else begin
            PSLVERR_O <= next_pslverr;
        end
    end

    // access phase answers one cycle after setup
    assign PREADY_O = 1'b1;
    assign FLASH_OP_O = run_op;
    assign FLASH_PTR_O = last_ptr;
    assign CPU_HALT_O = halt;
    assign CONC_BUSY_O = busy;
    // level interrupt, high while any unmasked status bit is set
    assign IRQ_O = |(irq_stat & irq_mask);

endmodule

// ==== test/flash_macro_model.sv ====
// flash macro model: ends each started erase or write after a set delay
`timescale 1ns/1ps
module flash_macro_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [3:0] lat_i,
    output logic done_o
);
    logic [4:0] cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 5'h00;
        end else if (start_i) begin
            cnt <= {1'b0, lat_i} + 5'h01;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end
    end
    assign done_o = (cnt == 5'h01);
endmodule

// ==== test/flash_self_program_access_chk.sv ====
// port checks for the self-programming access block
`timescale 1ns/1ps
module flash_self_program_access_chk (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PENABLE_I,
    input wire logic PROG_REQ_I,
    input wire flash_self_program_access_pkg::prog_op_t PROG_OP_I,
    input wire logic [11:0] PROG_PC_I,
    input wire logic FLASH_START_O,
    input wire logic [12:0] FLASH_PTR_O,
    input wire logic FLASH_DONE_I,
    input wire logic PROG_DONE_O,
    input wire logic PROG_REFUSED_O,
    input wire logic CPU_HALT_O,
    input wire logic CONC_BUSY_O
);
    import flash_self_program_access_pkg::*;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_ref;
        PROG_REQ_I && PROG_OP_I != OP_LOAD && PROG_PC_I < 12'hc00
            |=> PROG_REFUSED_O && !FLASH_START_O;
    endproperty
    a_ref: assert property (p_ref) else $error("app request ran");
    property p_start;
        FLASH_START_O |-> $past(PROG_REQ_I) && $past(PROG_PC_I) >= 12'hc00;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_halt;
        FLASH_START_O && FLASH_PTR_O[12:1] >= 12'hc00 |-> CPU_HALT_O;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_conc;
        FLASH_START_O && FLASH_PTR_O[12:1] < 12'hc00 |-> CONC_BUSY_O && !CPU_HALT_O;
    endproperty
    a_conc: assert property (p_conc) else $error("bad concurrent start");
    property p_hold;
        CPU_HALT_O && !FLASH_DONE_I |=> CPU_HALT_O;
    endproperty
    a_hold: assert property (p_hold) else $error("halt dropped");
    property p_resume;
        CPU_HALT_O && FLASH_DONE_I |=> PROG_DONE_O ##1 !CPU_HALT_O;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_busy;
        CONC_BUSY_O && !PROG_REQ_I && !PENABLE_I |=> CONC_BUSY_O;
    endproperty
    a_busy: assert property (p_busy) else $error("busy dropped");
    property p_load;
        PROG_REQ_I && PROG_OP_I == OP_LOAD && PROG_PC_I >= 12'hf80
            |=> PROG_DONE_O && !CONC_BUSY_O;
    endproperty
    a_load: assert property (p_load) else $error("load kept busy");
    c_halt: cover property (FLASH_START_O && CPU_HALT_O);
    c_conc: cover property (FLASH_START_O && CONC_BUSY_O);
    c_ref: cover property (PROG_REFUSED_O);
endmodule
bind flash_self_program_access flash_self_program_access_chk i_flash_self_program_access_chk (
    .CLK_I, .RST_I, .PENABLE_I, .PROG_REQ_I, .PROG_OP_I, .PROG_PC_I, .FLASH_START_O,
    .FLASH_PTR_O, .FLASH_DONE_I, .PROG_DONE_O, .PROG_REFUSED_O, .CPU_HALT_O, .CONC_BUSY_O
);

// ==== test/flash_self_program_access_bench.sv ====
// self-checking bench for the self-programming access block
`timescale 1ns/1ps
module flash_self_program_access_bench;
    import flash_self_program_access_pkg::*;
    typedef struct packed {
        logic [1:0] fuse;
        prog_op_t op;
        logic [11:0] pc;
        logic [12:0] ptr;
        logic [1:0] kind;
    } row_t;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, req = 1'b0, cer = 1'b0;
    logic [11:0] paddr = 12'h000, pc = 12'h000;
    logic [31:0] pwd = 32'h0, rd, prd;
    logic [1:0] fuse = 2'h0, k;
    prog_op_t op = OP_NONE;
    logic [12:0] ptr = 13'h0000;
    logic [3:0] lat = 4'h0;
    logic pready, perr, rerr, done, refd, start, fdone, halt, busy, irq, eb = 1'b0;
    prog_op_t fop;
    logic [12:0] fptr;
    int errors = 0, compares = 0, n;
    // kind: 0 refused, 1 load, 2 concurrent-read run, 3 halting run
    row_t rows[11] = '{'{2'h0, OP_ERASE, 12'hc00, 13'h17fe, 2'h2},
        '{2'h0, OP_LOAD, 12'hc00, 13'h0000, 2'h1}, '{2'h0, OP_WRITE, 12'hc00, 13'h1800, 2'h3},
        '{2'h0, OP_ERASE, 12'hbff, 13'h1800, 2'h0}, '{2'h1, OP_ERASE, 12'hdff, 13'h0000, 2'h0},
        '{2'h1, OP_WRITE, 12'he00, 13'h1ffe, 2'h3}, '{2'h2, OP_WRITE, 12'heff, 13'h0000, 2'h0},
        '{2'h2, OP_ERASE, 12'hf00, 13'h0000, 2'h2}, '{2'h3, OP_LOAD, 12'hf7f, 13'h0000, 2'h0},
        '{2'h3, OP_LOAD, 12'hf80, 13'h0000, 2'h1}, '{2'h3, OP_NONE, 12'hf80, 13'h0000, 2'h0}};
    flash_self_program_access i_flash_self_program_access (
        .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
        .BOOT_SIZE_FUSES_I(fuse), .CHIP_ERASE_I(cer), .PROG_REQ_I(req), .PROG_OP_I(op),
        .PROG_PC_I(pc), .PROG_PTR_I(ptr), .PROG_DONE_O(done), .PROG_REFUSED_O(refd),
        .FLASH_START_O(start), .FLASH_OP_O(fop), .FLASH_PTR_O(fptr), .FLASH_DONE_I(fdone),
        .CPU_HALT_O(halt), .CONC_BUSY_O(busy), .IRQ_O(irq)
    );
    flash_macro_model i_flash_macro_model (
        .clk_i(clk), .rst_i(rst), .start_i(start), .lat_i(lat), .done_o(fdone)
    );
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] b(input logic x);
        return {31'h0, x};
    endfunction
    task automatic test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            test_done;
        end
        rd = prd;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        #1;
    endtask
    task automatic prog_req(input row_t r);
        @(posedge clk);
        req <= 1'b1;
        op <= r.op;
        pc <= r.pc;
        ptr <= r.ptr;
        @(posedge clk);
        req <= 1'b0;
        #1;
    endtask
    task automatic wait_done;
        for (n = 0; n < 40 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 40) begin
            errors++;
            test_done;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("ready", b(pready), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check("lock", rd, 32'hf);
        apb(1'b1, 12'h010, 32'h1);
        foreach (rows[i]) begin
            @(posedge clk);
            fuse <= rows[i].fuse;
            lat <= 4'(i * 5);
            repeat (3) @(posedge clk);
            k = rows[i].kind;
            prog_req(rows[i]);
            check("refused", b(refd), b(k == 2'h0));
            check("start", b(start), b(k[1]));
            check("halt", b(halt), b(k == 2'h3));
            check("done", b(done), b(k == 2'h1));
            if (k[1]) begin
                check("op", {30'h0, fop}, {30'h0, rows[i].op});
                check("ptr", {19'h0, fptr}, {19'h0, rows[i].ptr});
                wait_done;
                @(posedge clk);
                #1;
                check("resume", b(halt), 32'h0);
            end
            // loads follow only finished runs
            eb = k == 2'h2 ? 1'b1 : k == 2'h1 ? 1'b0 : eb;
            check("busy", b(busy), b(eb));
            check("irq", b(irq), b(k != 2'h0));
            apb(1'b1, 12'h00c, 32'h3);
            check("irq clear", b(irq), 32'h0);
            apb(1'b0, 12'h004, 32'h0);
            check("status", rd & 32'h1, b(eb));
        end
        @(posedge clk);
        lat <= 4'hf;
        prog_req('{2'h3, OP_ERASE, 12'hf80, 13'h0000, 2'h2});
        apb(1'b1, 12'h000, 32'h1);
        check("busy run", b(busy), 32'h1);
        wait_done;
        apb(1'b1, 12'h000, 32'h1);
        check("busy idle", b(busy), 32'h0);
        apb(1'b1, 12'h008, 32'he);
        prog_req('{2'h3, OP_ERASE, 12'hf80, 13'h0000, 2'h0});
        check("locked", b(refd), 32'h1);
        prog_req('{2'h3, OP_WRITE, 12'hf80, 13'h1f00, 2'h3});
        check("boot open", b(start), 32'h1);
        wait_done;
        apb(1'b1, 12'h008, 32'hf);
        apb(1'b0, 12'h008, 32'h0);
        check("lock kept", rd, 32'he);
        @(posedge clk);
        cer <= 1'b1;
        repeat (3) @(posedge clk);
        cer <= 1'b0;
        apb(1'b0, 12'h008, 32'h0);
        check("lock erased", rd, 32'hf);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", b(rerr), 32'h1);
        // reset in the middle of a halting run
        @(posedge clk);
        lat <= 4'hf;
        prog_req('{2'h3, OP_WRITE, 12'hf80, 13'h1f00, 2'h3});
        check("halt before reset", b(halt), 32'h1);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("halt after reset", b(halt), 32'h0);
        check("busy after reset", b(busy), 32'h0);
        check("done after reset", b(done), 32'h0);
        test_done;
    end
endmodule
